//--- core/sbc_cfg_pkg.sv
/*
 Package for the miscellaneous configuration and secured mode block:
 frame layout, register offsets, reset values, timing counts, types.
 Assumes a 20 MHz system clock and 16-bit serial frames, MSB first.
*/
package sbc_cfg_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int INT_LONG_NS = 100000;
   localparam int INT_SHORT_NS = 25000;
   localparam logic [11:0] INT_LONG_CYC = 12'(INT_LONG_NS / CLK_PERIOD_NS);
   localparam logic [11:0] INT_SHORT_CYC = 12'(INT_SHORT_NS / CLK_PERIOD_NS);

   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] HEADER_BITS = 5'h08;
   localparam logic [1:0] CMD_READ = 2'h0;
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [4:0] OFS_MISC = 5'h08;
   localparam logic [4:0] OFS_MODE = 5'h09;
   localparam int FRM_CMD_POS = 14;
   localparam int FRM_ADDR_POS = 9;
   localparam int FRM_PARITY_POS = 8;
   localparam logic [7:0] MISC_RESET = 8'h00;
   localparam logic [5:0] LFSR_SEED = 6'h2D;

   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [1:0] SEL_INIT = 2'h1;
   localparam logic [1:0] SEL_FLASH = 2'h2;
   localparam logic [1:0] SEL_NONE = 2'h3;

   localparam logic [1:0] FS_VARIANT_A = 2'h0;
   localparam logic [1:0] FS_VARIANT_B1 = 2'h1;
   localparam logic [1:0] FS_VARIANT_B2 = 2'h2;
   localparam logic [1:0] FS_VARIANT_B3 = 2'h3;

   typedef enum logic [1:0] {
      dev_reset, dev_init, dev_normal, dev_flash
   } dev_state_e;

   typedef struct packed {
      logic coded_lowpower_entry_enable;
      logic parity_enable;
      logic int_level_mode;
      logic int_short_pulse;
      logic mid_period_int_enable;
      logic [2:0] dbg_res_sel;
   } misc_cfg_s;

   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [2:0] cs_sync;
      logic [2:0] mosi_sync;
      logic [4:0] bit_cnt;
      logic [15:0] rx;
      logic [15:0] tx;
      logic miso;
      misc_cfg_s misc;
      logic [5:0] lfsr;
      logic [5:0] code;
      logic code_valid;
      logic mode_req;
      logic [1:0] mode_target;
      logic [11:0] int_cnt;
      logic int_hold;
      logic int_n;
      logic dbg_flag;
      logic [1:0] variant;
      logic parity_err;
   } core_state_s;
endpackage : sbc_cfg_pkg

//--- core/sbc_misc_config_and_mode_select.sv
/*
 Serial register slave for the miscellaneous init register and the
 secured mode select register, with interrupt pin shaping and debug
 resistor fail-safe override.
 Assumes the serial clock is at most one eighth of clk and that state,
 watchdog and resistor inputs come from logic on clk.
*/
// Operation
// - The misc register takes writes only in the init state.
// - With the coded entry bit set, low-power entry needs random code bits 2..0.
// - With parity on, writes with a wrong frame parity are discarded.
// - The shape bit chooses a low pulse or a permanent low on the interrupt pin.
// - The width bit chooses a 100 us or a 25 us interrupt pulse.
// - With the mid-period bit set in flash state, half watchdog period pulses it.
// - A selection field with top bit clear disables check and override.
// - Codes 100, 101, 110 check and select variants B3, B2, B1.
// - Code 111 checks and selects variant A.
// - A detected resistor unlike the selected one sets the debug flag.
// - With the top bit set the selected variant overrides the hardware one.
// - The target field selects reset, init or flash; code 11 does nothing.
// - The mode write carries the inverted random code in bits 5..0.
// - A mode register read returns a fresh random code in bits 5..0.
`timescale 1ns/10ps
module sbc_misc_config_and_mode_select (
   input wire logic clk,
   input wire logic resetn,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input sbc_cfg_pkg::dev_state_e dev_state,
   input wire logic wd_half_elapsed,
   input wire logic int_event,
   input wire logic int_release,
   input wire logic [1:0] hw_variant,
   input wire logic dbg_flag_clear,
   output logic int_n,
   output logic coded_lowpower_entry_enable,
   output logic [2:0] lowpower_code,
   output logic mode_req,
   output logic [1:0] mode_target,
   output logic [1:0] failsafe_variant,
   output logic dbg_resistor_flag,
   output logic parity_error
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   sbc_cfg_pkg::core_state_s s_q;
   sbc_cfg_pkg::core_state_s s_d;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic frame_end;
   logic wr_cmd;
   logic parity_ok;
   logic wr_ok;
   logic misc_wr;
   logic mode_wr;
   logic code_match;
   logic int_trig;
   logic [1:0] sel_variant;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   always_comb begin
      sclk_rise = s_q.sclk_sync[1] && !s_q.sclk_sync[2];
      sclk_fall = !s_q.sclk_sync[1] && s_q.sclk_sync[2];
      cs_fall = !s_q.cs_sync[1] && s_q.cs_sync[2];
      cs_rise = s_q.cs_sync[1] && !s_q.cs_sync[2];
      frame_end = cs_rise && (s_q.bit_cnt == sbc_cfg_pkg::FRAME_BITS);
      wr_cmd = s_q.rx[15:sbc_cfg_pkg::FRM_CMD_POS] == sbc_cfg_pkg::CMD_WRITE;
      parity_ok = !s_q.misc.parity_enable || !(^s_q.rx);
      wr_ok = frame_end && wr_cmd && parity_ok;
      misc_wr = wr_ok && (s_q.rx[13:sbc_cfg_pkg::FRM_ADDR_POS]
                == sbc_cfg_pkg::OFS_MISC) && (dev_state == sbc_cfg_pkg::dev_init);
      mode_wr = wr_ok && (s_q.rx[13:sbc_cfg_pkg::FRM_ADDR_POS]
                == sbc_cfg_pkg::OFS_MODE);
      code_match = s_q.code_valid && (s_q.rx[5:0] == ~s_q.code);
      int_trig = int_event || (wd_half_elapsed && s_q.misc.mid_period_int_enable
                 && dev_state == sbc_cfg_pkg::dev_flash);
      unique case (s_q.misc.dbg_res_sel[1:0])
         2'h0: sel_variant = sbc_cfg_pkg::FS_VARIANT_B3;
         2'h1: sel_variant = sbc_cfg_pkg::FS_VARIANT_B2;
         2'h2: sel_variant = sbc_cfg_pkg::FS_VARIANT_B1;
         2'h3: sel_variant = sbc_cfg_pkg::FS_VARIANT_A;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.sclk_sync = {s_q.sclk_sync[1:0], spi_sclk};
      s_d.cs_sync = {s_q.cs_sync[1:0], spi_cs_n};
      s_d.mosi_sync = {s_q.mosi_sync[1:0], spi_mosi};
      s_d.lfsr = {s_q.lfsr[4:0], s_q.lfsr[5] ^ s_q.lfsr[4]};
      s_d.mode_req = 1'b0;
      s_d.parity_err = 1'b0;
      // Frame reception and reply shifting
      if (cs_fall) begin
         s_d.bit_cnt = 5'h00;
         s_d.tx = 16'h0000;
      end else if (!s_q.cs_sync[2]) begin
         if (sclk_rise && s_q.bit_cnt != sbc_cfg_pkg::FRAME_BITS) begin
            s_d.rx = {s_q.rx[14:0], s_q.mosi_sync[2]};
            s_d.bit_cnt = s_q.bit_cnt + 5'h01;
         end
         if (sclk_fall) begin
            s_d.miso = s_q.tx[15];
            s_d.tx = {s_q.tx[14:0], 1'b0};
            if (s_q.bit_cnt == sbc_cfg_pkg::HEADER_BITS) begin
               s_d.miso = 1'b0;
               s_d.tx = 16'h0000;
               if (s_q.rx[7:6] == sbc_cfg_pkg::CMD_READ) begin
                  if (s_q.rx[5:1] == sbc_cfg_pkg::OFS_MODE) begin
                     s_d.miso = 1'b0;
                     s_d.tx = {1'b0, s_q.lfsr, 9'h000};
                     s_d.code = s_q.lfsr;
                     s_d.code_valid = 1'b1;
                  end else if (s_q.rx[5:1] == sbc_cfg_pkg::OFS_MISC) begin
                     s_d.miso = s_q.misc.coded_lowpower_entry_enable;
                     s_d.tx = {s_q.misc[6:0], 9'h000};
                  end
               end
            end
         end
      end
      if (frame_end && wr_cmd && !parity_ok) begin
         s_d.parity_err = 1'b1;
      end
      if (misc_wr) begin
         s_d.misc = sbc_cfg_pkg::misc_cfg_s'(s_q.rx[7:0]);
      end
      if (mode_wr) begin
         s_d.code_valid = 1'b0;
         if (code_match && s_q.rx[7:6] != sbc_cfg_pkg::SEL_NONE) begin
            s_d.mode_req = 1'b1;
            s_d.mode_target = s_q.rx[7:6];
         end
      end
      // Interrupt pin shaping
      if (s_q.int_cnt != 12'h000) begin
         s_d.int_cnt = s_q.int_cnt - 12'h001;
      end
      if (int_release) begin
         s_d.int_hold = 1'b0;
      end
      if (int_trig) begin
         if (s_q.misc.int_level_mode) begin
            s_d.int_hold = 1'b1;
         end else if (s_q.misc.int_short_pulse) begin
            s_d.int_cnt = sbc_cfg_pkg::INT_SHORT_CYC;
         end else begin
            s_d.int_cnt = sbc_cfg_pkg::INT_LONG_CYC;
         end
      end
      s_d.int_n = !(s_d.int_hold || s_d.int_cnt != 12'h000);
      // Debug resistor check and fail-safe override
      if (s_q.misc.dbg_res_sel[2]) begin
         s_d.variant = sel_variant;
      end else begin
         s_d.variant = hw_variant;
      end
      if (dbg_flag_clear) begin
         s_d.dbg_flag = 1'b0;
      end
      if (s_q.misc.dbg_res_sel[2] && hw_variant != sel_variant) begin
         s_d.dbg_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.sclk_sync <= 3'h0;
         s_q.cs_sync <= 3'h7;
         s_q.misc <= sbc_cfg_pkg::misc_cfg_s'(sbc_cfg_pkg::MISC_RESET);
         s_q.lfsr <= sbc_cfg_pkg::LFSR_SEED;
         s_q.int_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign spi_miso = s_q.miso;
   assign int_n = s_q.int_n;
   assign coded_lowpower_entry_enable = s_q.misc.coded_lowpower_entry_enable;
   assign lowpower_code = s_q.code[2:0];
   assign mode_req = s_q.mode_req;
   assign mode_target = s_q.mode_target;
   assign failsafe_variant = s_q.variant;
   assign dbg_resistor_flag = s_q.dbg_flag;
   assign parity_error = s_q.parity_err;

   sequence s_pulse_start;
      int_trig && !s_q.misc.int_level_mode;
   endsequence
   sequence s_short_low;
      !int_n [*8];
   endsequence

   property p_misc_locked;
      @(posedge clk) disable iff (!rst_n)
      (dev_state != sbc_cfg_pkg::dev_init) |=> $stable(s_q.misc);
   endproperty
   a_misc_locked: assert property (p_misc_locked)
      else $error("misc register changed outside init");

   property p_parity_drop;
      @(posedge clk) disable iff (!rst_n)
      (frame_end && wr_cmd && s_q.misc.parity_enable && (^s_q.rx))
      |=> parity_error && !mode_req && $stable(s_q.misc);
   endproperty
   a_parity_drop: assert property (p_parity_drop)
      else $error("write with bad parity was taken");

   property p_mode_match;
      @(posedge clk) disable iff (!rst_n)
      mode_req |-> $past(code_match) && $past(mode_wr);
   endproperty
   a_mode_match: assert property (p_mode_match)
      else $error("mode request without matching code");

   property p_mode_code11;
      @(posedge clk) disable iff (!rst_n)
      mode_req |-> mode_target != sbc_cfg_pkg::SEL_NONE;
   endproperty
   a_mode_code11: assert property (p_mode_code11)
      else $error("mode request with target 11");

   property p_pulse_low;
      @(posedge clk) disable iff (!rst_n)
      s_pulse_start ##1 !int_trig |=> s_short_low;
   endproperty
   a_pulse_low: assert property (p_pulse_low)
      else $error("interrupt pulse too short");

   property p_pulse_len;
      @(posedge clk) disable iff (!rst_n)
      (int_trig && !s_q.misc.int_level_mode && s_q.misc.int_short_pulse)
      |=> s_q.int_cnt == sbc_cfg_pkg::INT_SHORT_CYC;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("short pulse length wrong");

   property p_level_hold;
      @(posedge clk) disable iff (!rst_n)
      (int_trig && s_q.misc.int_level_mode) ##1 !int_release
      |=> !int_n;
   endproperty
   a_level_hold: assert property (p_level_hold)
      else $error("level interrupt not held low");

   property p_mid_period;
      @(posedge clk) disable iff (!rst_n)
      (wd_half_elapsed && s_q.misc.mid_period_int_enable
       && dev_state == sbc_cfg_pkg::dev_flash) |=> ##1 !int_n;
   endproperty
   a_mid_period: assert property (p_mid_period)
      else $error("no interrupt at half watchdog period");

   property p_override;
      @(posedge clk) disable iff (!rst_n)
      !s_q.misc.dbg_res_sel[2] |=> failsafe_variant == $past(hw_variant);
   endproperty
   a_override: assert property (p_override)
      else $error("variant overridden while disabled");

   property p_dbg_flag;
      @(posedge clk) disable iff (!rst_n)
      (s_q.misc.dbg_res_sel[2] && hw_variant != sel_variant)
      |=> dbg_resistor_flag;
   endproperty
   a_dbg_flag: assert property (p_dbg_flag)
      else $error("debug flag not set on mismatch");

   property p_parity_off;
      @(posedge clk) disable iff (!rst_n)
      (frame_end && wr_cmd && !s_q.misc.parity_enable) |=> !parity_error;
   endproperty
   a_parity_off: assert property (p_parity_off)
      else $error("parity checked while disabled");

   property p_variant_sel;
      @(posedge clk) disable iff (!rst_n)
      s_q.misc.dbg_res_sel[2] |=> failsafe_variant == $past(sel_variant);
   endproperty
   a_variant_sel: assert property (p_variant_sel)
      else $error("selected variant did not override hardware");

   property p_int_release;
      @(posedge clk) disable iff (!rst_n)
      (int_release && !int_trig && s_q.int_cnt == 12'h000) |=> int_n;
   endproperty
   a_int_release: assert property (p_int_release)
      else $error("interrupt not released");
endmodule : sbc_misc_config_and_mode_select

//--- testbench/spi_host_model.sv
/*
 Host side of the serial link: 16-bit frames, MSB first, sclk idles low.
 Assumes the bench clk; every edge is placed on a clk falling edge.
*/
`timescale 1ns/10ps
module spi_host_model (
   input wire logic clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // Parity bit of writes: zero when off, even frame parity when on
   task automatic xfer(input logic [15:0] f, input logic par_on,
      input logic bad, output logic [15:0] rx);
      if (f[15:14] == sbc_cfg_pkg::CMD_WRITE) begin
         f[8] = (par_on & (^{f[15:9], f[7:0]})) ^ bad;
      end
      rx = 16'h0000;
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi <= f[i];
         repeat (4) @(negedge clk);
         rx = {rx[14:0], spi_miso};
         spi_sclk <= 1'b1;
         repeat (4) @(negedge clk);
         spi_sclk <= 1'b0;
      end
      repeat (4) @(negedge clk);
      spi_cs_n <= 1'b1;
      spi_mosi <= ~f[0];
      repeat (8) @(negedge clk);
   endtask : xfer
endmodule : spi_host_model

//--- testbench/testbench.sv
/*
 Self-checking bench for the misc config and secured mode block.
 Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t got %h exp %h", $time, a, b); end end
module testbench;
   logic clk, resetn, sclk, cs_n, mosi, miso, wd_half, int_event;
   logic int_release, dbg_clear, int_n, lp_en, mode_req, dbg_flag, perr;
   logic par;
   logic [1:0] hw_var, mode_tgt, variant, last_tgt;
   logic [2:0] lp_code;
   logic [5:0] code;
   logic [15:0] rx;
   sbc_cfg_pkg::dev_state_e state;
   int num_errors = 0, cmp_count = 0, req_cnt = 0, perr_cnt = 0, n;

   spi_host_model i_host (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso));
   sbc_misc_config_and_mode_select i_dut (.clk(clk), .resetn(resetn),
      .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
      .dev_state(state), .wd_half_elapsed(wd_half), .int_event(int_event),
      .int_release(int_release), .hw_variant(hw_var),
      .dbg_flag_clear(dbg_clear), .int_n(int_n),
      .coded_lowpower_entry_enable(lp_en), .lowpower_code(lp_code),
      .mode_req(mode_req), .mode_target(mode_tgt),
      .failsafe_variant(variant), .dbg_resistor_flag(dbg_flag),
      .parity_error(perr));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(negedge clk) begin
      if (mode_req === 1'b1) begin
         req_cnt++;
         last_tgt = mode_tgt;
      end
      if (perr === 1'b1) begin
         perr_cnt++;
      end
   end

   task automatic wr(input logic [4:0] a, input logic [7:0] d,
      input logic bad = 1'b0);
      i_host.xfer({sbc_cfg_pkg::CMD_WRITE, a, 1'b0, d}, par, bad, rx);
   endtask : wr

   task automatic rd(input logic [15:0] f);
      i_host.xfer(f, par, 1'b0, rx);
   endtask : rd

   // Fires one interrupt cause and counts the low cycles of int_n
   task automatic int_len(input logic wd, output int len);
      wd_half <= wd;
      int_event <= ~wd;
      @(negedge clk);
      wd_half <= 1'b0;
      int_event <= 1'b0;
      len = 0;
      repeat (3000) begin
         if (int_n === 1'b0) begin
            len++;
         end
         @(negedge clk);
      end
   endtask : int_len

   task automatic complete_run();
      $display("Comparisons %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   initial begin
      #3000000;
      num_errors++;
      complete_run();
   end

   initial begin
      resetn = 1'b0;
      state = sbc_cfg_pkg::dev_normal;
      {wd_half, int_event, int_release, dbg_clear, par} = 5'h00;
      hw_var = sbc_cfg_pkg::FS_VARIANT_B2;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      repeat (6) @(negedge clk);
      `CHK({int_n, lp_en, mode_req, dbg_flag, perr}, 5'h10)
      wr(sbc_cfg_pkg::OFS_MISC, 8'h80);
      rd(16'h1000);
      `CHK(rx[7:0], sbc_cfg_pkg::MISC_RESET)
      state = sbc_cfg_pkg::dev_init;
      wr(sbc_cfg_pkg::OFS_MISC, 8'h80);
      `CHK(lp_en, 1'b1)
      for (int c = 0; c < 8; c++) begin
         wr(sbc_cfg_pkg::OFS_MISC, 8'(c));
         `CHK(variant, c[2] ? 2'(7 - c) : hw_var)
         `CHK(dbg_flag, c > 3)
      end
      wr(sbc_cfg_pkg::OFS_MISC, 8'h05);
      dbg_clear <= 1'b1;
      @(negedge clk);
      dbg_clear <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(dbg_flag, 1'b0)
      wr(sbc_cfg_pkg::OFS_MISC, 8'h00);
      int_len(1'b0, n);
      `CHK(12'(n), sbc_cfg_pkg::INT_LONG_CYC)
      wr(sbc_cfg_pkg::OFS_MISC, 8'h18);
      int_len(1'b0, n);
      `CHK(12'(n), sbc_cfg_pkg::INT_SHORT_CYC)
      state = sbc_cfg_pkg::dev_flash;
      int_len(1'b1, n);
      `CHK(12'(n), sbc_cfg_pkg::INT_SHORT_CYC)
      state = sbc_cfg_pkg::dev_normal;
      int_len(1'b1, n);
      `CHK(n, 0)
      state = sbc_cfg_pkg::dev_init;
      wr(sbc_cfg_pkg::OFS_MISC, 8'h20);
      int_len(1'b0, n);
      `CHK(n > 2990, 1'b1)
      int_release <= 1'b1;
      @(negedge clk);
      int_release <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(int_n, 1'b1)
      rd(16'h1300);
      code = rx[5:0];
      `CHK(lp_code, code[2:0])
      rd(16'h1300);
      `CHK(rx[5:0] !== code, 1'b1)
      for (int s = 0; s < 4; s++) begin
         rd(16'h1300);
         n = req_cnt;
         wr(sbc_cfg_pkg::OFS_MODE, {2'(s), ~rx[5:0]});
         `CHK(req_cnt - n, (s == 3) ? 0 : 1)
         `CHK(last_tgt, (s == 3) ? 2'h2 : 2'(s))
      end
      rd(16'h1300);
      code = ~rx[5:0];
      n = req_cnt;
      wr(sbc_cfg_pkg::OFS_MODE, {2'h1, code ^ 6'h01});
      `CHK(req_cnt, n)
      rd(16'h1300);
      code = ~rx[5:0];
      wr(sbc_cfg_pkg::OFS_MODE, {2'h2, code});
      wr(sbc_cfg_pkg::OFS_MODE, {2'h2, code});
      `CHK(req_cnt, n + 1)
      wr(sbc_cfg_pkg::OFS_MISC, 8'h40);
      par = 1'b1;
      n = perr_cnt;
      wr(sbc_cfg_pkg::OFS_MISC, 8'h41, 1'b1);
      `CHK(perr_cnt - n, 1)
      rd(16'h1000);
      `CHK(rx[7:0], 8'h40)
      wr(sbc_cfg_pkg::OFS_MISC, 8'h41);
      rd(16'h1000);
      `CHK(rx[7:0], 8'h41)
      complete_run();
   end
endmodule : testbench
